// >>> hw/rsf_pkg.sv
// shared constants for the reset source flag logic
package rsf_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_LEVEL = 8'h04;
  localparam logic [7:0] OFS_WDOG_CTL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ST = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // cause register fields
  localparam int CAUSE_WCTL_BIT = 0;
  localparam int CAUSE_LEVEL_BIT = 1;
  localparam int CAUSE_BROWN_BIT = 2;
  localparam int CAUSE_KEEP_ON_BIT = 7;
  // status register fields
  localparam int STAT_PDOWN_BIT = 0;
  localparam int STAT_TMO_BIT = 1;
  // brownout level codes
  localparam logic [7:0] LEVEL_POR = 8'h55;
  localparam logic [7:0] LEVEL_CODE_A = 8'h55;
  localparam logic [7:0] LEVEL_CODE_B = 8'h33;
  localparam logic [7:0] LEVEL_CODE_C = 8'h99;
  localparam logic [7:0] LEVEL_CODE_D = 8'haa;
  // watchdog enable codes
  localparam logic [4:0] WCTL_ENABLE = 5'h0a;
  localparam logic [4:0] WCTL_DISABLE = 5'h15;
  localparam logic [4:0] WCTL_POR = 5'h0a;
  // interrupt event bits
  localparam int IRQ_W = 5;
  localparam int IRQ_BROWN = 0;
  localparam int IRQ_LEVEL = 1;
  localparam int IRQ_WCTL = 2;
  localparam int IRQ_WDOG_RUN = 3;
  localparam int IRQ_WDOG_HALT = 4;
  // timing
  localparam real T_HOLD_MS = 16.7;
  localparam int CLK_KHZ = 200000;
  localparam int HOLD_CYCLES = int'(T_HOLD_MS * real'(CLK_KHZ));
  localparam int SRESET_CYCLES = 32;
  // reset sequencer states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DELAY = 2'b01,
    ST_HOLD = 2'b10
  } seq_t;
endpackage

// >>> hw/timer_if.sv
// start and done handshake between sequencer and a delay timer
`timescale 1ns/1ps
interface timer_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface

// >>> hw/delay_timer.sv
// one-shot down counter, done pulses CYCLES cycles after start
`timescale 1ns/1ps
module delay_timer
  import rsf_pkg::*;
#(
  parameter int CYCLES = 4
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  timer_if.tmr tm
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  localparam logic [CW-1:0] ONE = CW'(1);
  logic [CW-1:0] cnt_q;

  // a new start restarts the count
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (tm.start)
      cnt_q <= LOAD;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - ONE;
  end

  assign tm.busy = (cnt_q != '0);
  assign tm.done = (cnt_q == ONE) && !tm.start;
endmodule // delay_timer

// >>> hw/sticky_reg.sv
// bank of sticky flags, a set beats a clear in the same cycle
`timescale 1ns/1ps
module sticky_reg
  import rsf_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  output logic [W-1:0] q
);
  // set wins so no event is lost under a clear
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= set | (q & ~clr);
  end
endmodule // sticky_reg

// >>> hw/reset_source_flag_logic.sv
// reset cause tracking, reset effects and apb register file
`timescale 1ns/1ps
module reset_source_flag_logic
  import rsf_pkg::*;
#(
  parameter int HOLD_CYC = HOLD_CYCLES,
  parameter int SRESET_CYC = SRESET_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brownout_det,
  input wire logic watchdog_timeout,
  input wire logic low_power,
  input wire logic halt_enter,
  input wire logic status_clr,
  output logic cpu_hold,
  output logic irq_disable,
  output logic timer_off,
  output logic port_input,
  output logic sp_top,
  output logic sp_zero,
  output logic pc_clear,
  output logic watchdog_restart,
  output logic system_clock_keep_on,
  output logic irq
);
  seq_t state_q;
  logic brown_s1_q, brown_s2_q, brown_s3_q;
  logic full_init_q, halt_clr_q;
  logic lvl_pend_q, wctl_pend_q;
  logic timeout_flag_q, power_down_flag_q;
  logic keep_on_q;
  logic [7:0] brownout_level_select_q;
  logic [4:0] wdog_ctl_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [2:0] cause_q;
  logic [2:0] cause_set;
  logic [2:0] cause_clr;
  logic brown_evt, wdog_run_evt, wdog_halt_evt;
  logic lvl_bad, wctl_bad, soft_go, full_go;
  logic acc, wr, hit;
  logic [31:0] rdata;

  timer_if sres_t ();
  timer_if hold_t ();

  delay_timer #(.CYCLES(SRESET_CYC)) u_sreset (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tm(sres_t)
  );

  delay_timer #(.CYCLES(HOLD_CYC)) u_hold (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tm(hold_t)
  );

  // brownout detector is analog, so synchronise it first; third stage finds the edge
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      {brown_s3_q, brown_s2_q, brown_s1_q} <= 3'h0;
    else
      {brown_s3_q, brown_s2_q, brown_s1_q} <= {brown_s2_q, brown_s1_q, brownout_det};
  end

  // event decode; the detector is off while powered down
  assign brown_evt = brown_s2_q && !brown_s3_q && !low_power;
  assign wdog_run_evt = watchdog_timeout && !low_power;
  assign wdog_halt_evt = watchdog_timeout && low_power;

  // code checks
  assign lvl_bad = (brownout_level_select_q != LEVEL_CODE_A)
    && (brownout_level_select_q != LEVEL_CODE_B)
    && (brownout_level_select_q != LEVEL_CODE_C)
    && (brownout_level_select_q != LEVEL_CODE_D);
  assign wctl_bad = (wdog_ctl_q != WCTL_ENABLE) && (wdog_ctl_q != WCTL_DISABLE);

  assign soft_go = (state_q == ST_DELAY) && sres_t.done;
  // run timeout is a full reset
  assign full_go = brown_evt || wdog_run_evt || soft_go;

  assign sres_t.start = (state_q == ST_RUN) && (lvl_bad || wctl_bad) && !full_go;
  // every full reset restarts the hold-off
  assign hold_t.start = full_go;

  // reset sequencer
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= ST_RUN;
    else if (full_go)
      state_q <= ST_HOLD;
    else
    begin
      case (state_q)
        ST_RUN:
          if (lvl_bad || wctl_bad)
            state_q <= ST_DELAY;
        ST_DELAY:
          state_q <= ST_DELAY;
        ST_HOLD:
          if (hold_t.done)
            state_q <= ST_RUN;
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  // which bad code started the delay, kept until it fires
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || full_go)
      {lvl_pend_q, wctl_pend_q} <= 2'b00;
    else if (sres_t.start)
      {lvl_pend_q, wctl_pend_q} <= {lvl_bad, wctl_bad};
  end

  // full init pulse, high through power-on reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      full_init_q <= 1'b1;
    else
      full_init_q <= full_go;
  end

  // halted timeout only touches pc and sp
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      halt_clr_q <= 1'b0;
    else
      halt_clr_q <= wdog_halt_evt;
  end

  assign irq_disable = full_init_q;
  assign timer_off = full_init_q;
  assign port_input = full_init_q;
  assign sp_top = full_init_q;
  // watchdog and time-bases cleared and restarted
  assign watchdog_restart = full_init_q;
  // pc and sp cleared to zero
  assign sp_zero = halt_clr_q;
  assign pc_clear = full_init_q || halt_clr_q;
  assign cpu_hold = (state_q == ST_HOLD);
  assign system_clock_keep_on = keep_on_q;

  // bus decode; zero wait state slave
  assign acc = psel && penable;
  assign wr = acc && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // timeout flag: power-on zero, set by any timeout
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      timeout_flag_q <= 1'b0;
    else if (watchdog_timeout)
      timeout_flag_q <= 1'b1;
    else if (status_clr)
      timeout_flag_q <= 1'b0;
  end

  // power-down flag set by halt or halted timeout
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      power_down_flag_q <= 1'b0;
    else if (wdog_halt_evt || halt_enter)
      power_down_flag_q <= 1'b1;
    else if (status_clr)
      power_down_flag_q <= 1'b0;
  end

  // level select returns to its power-on value
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      brownout_level_select_q <= LEVEL_POR;
    else if (full_go)
      brownout_level_select_q <= LEVEL_POR;
    else if (wr && (paddr == OFS_LEVEL))
      brownout_level_select_q <= pwdata[7:0];
  end

  // watchdog enable code, restored by any full reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      wdog_ctl_q <= WCTL_POR;
    else if (full_go)
      wdog_ctl_q <= WCTL_POR;
    else if (wr && (paddr == OFS_WDOG_CTL))
      wdog_ctl_q <= pwdata[4:0];
  end

  // clock keep-on bit and interrupt mask
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      keep_on_q <= 1'b0;
      irq_mask_q <= '0;
    end
    else
    begin
      if (full_go)
        keep_on_q <= 1'b0;
      else if (wr && (paddr == OFS_CAUSE))
        keep_on_q <= pwdata[CAUSE_KEEP_ON_BIT];
      if (wr && (paddr == OFS_IRQ_MASK))
        irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  assign cause_set[CAUSE_BROWN_BIT] = brown_evt;
  // level flag set when its delayed reset fires
  assign cause_set[CAUSE_LEVEL_BIT] = soft_go && lvl_pend_q;
  assign cause_set[CAUSE_WCTL_BIT] = soft_go && wctl_pend_q;
  // software writes zero to clear; run timeout clears all
  assign cause_clr = (wr && (paddr == OFS_CAUSE) ? ~pwdata[2:0] : 3'h0)
    | {3{wdog_run_evt}};

  // flags start at zero after power-on
  sticky_reg #(.W(3)) u_cause (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set(cause_set),
    .clr(cause_clr),
    .q(cause_q)
  );

  // interrupt events, write one to clear
  assign irq_set[IRQ_BROWN] = brown_evt;
  assign irq_set[IRQ_LEVEL] = cause_set[CAUSE_LEVEL_BIT];
  assign irq_set[IRQ_WCTL] = cause_set[CAUSE_WCTL_BIT];
  assign irq_set[IRQ_WDOG_RUN] = wdog_run_evt;
  assign irq_set[IRQ_WDOG_HALT] = wdog_halt_evt;
  assign irq_clr = (wr && (paddr == OFS_IRQ_ST)) ? pwdata[IRQ_W-1:0] : '0;

  sticky_reg #(.W(IRQ_W)) u_irq (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .set(irq_set),
    .clr(irq_clr),
    .q(irq_st)
  );

  assign irq = |(irq_st & irq_mask_q);

  // read mux; cause bits six to three stay zero
  always_comb
  begin
    rdata = 32'h0;
    hit = 1'b1;
    case (paddr)
      OFS_CAUSE:
      begin
        rdata[2:0] = cause_q;
        rdata[CAUSE_KEEP_ON_BIT] = keep_on_q;
      end
      OFS_LEVEL: rdata[7:0] = brownout_level_select_q;
      OFS_WDOG_CTL: rdata[4:0] = wdog_ctl_q;
      OFS_STATUS:
      begin
        rdata[STAT_PDOWN_BIT] = power_down_flag_q;
        rdata[STAT_TMO_BIT] = timeout_flag_q;
      end
      OFS_IRQ_ST: rdata[IRQ_W-1:0] = irq_st;
      OFS_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_q;
      default: hit = 1'b0;
    endcase
  end

  assign prdata = acc ? rdata : 32'h0;

  // full reset: init pulse then hold
  sequence full_rst_s;
    full_init_q ##1 cpu_hold [*4];
  endsequence
  brown_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    brown_evt |=> cause_q[CAUSE_BROWN_BIT] and full_rst_s)
    else $error("brownout flag or reset missing");
  level_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_go && lvl_pend_q |=> cause_q[CAUSE_LEVEL_BIT])
    else $error("level flag not set");
  unused_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    acc && (paddr == OFS_CAUSE) |-> prdata[6:3] == 4'h0)
    else $error("unused cause bits not zero");
  run_timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_run_evt && !halt_enter && !status_clr
      |=> (timeout_flag_q && power_down_flag_q == $past(power_down_flag_q)) and full_rst_s)
    else $error("run timeout handling wrong");
  halt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_halt_evt && !full_go && !cpu_hold |=> sp_zero && pc_clear && !sp_top && !cpu_hold)
    else $error("halted timeout did more than pc and sp");
  por_flags_a: assert property (@(posedge clk_sys)
    !rst_n |=> !timeout_flag_q && !power_down_flag_q && full_init_q && cause_q == 3'h0)
    else $error("power-on state wrong");
  brown_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    brown_evt && !watchdog_timeout && !halt_enter && !status_clr
      |=> $stable(timeout_flag_q) && $stable(power_down_flag_q))
    else $error("brownout changed status flags");
  halt_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_halt_evt |=> timeout_flag_q && power_down_flag_q)
    else $error("halted timeout flags not set");
  wctl_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    soft_go && wctl_pend_q |=> cause_q[CAUSE_WCTL_BIT] && wdog_ctl_q == WCTL_POR)
    else $error("watchdog control flag not set");
  level_restore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_RUN && lvl_bad && !full_go |-> ##[1:64] full_init_q
      && brownout_level_select_q == LEVEL_POR)
    else $error("bad level code not reset in time");
  run_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wdog_run_evt && !brown_evt && !soft_go |=> cause_q == 3'h0)
    else $error("run timeout left cause flags");
  hold_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cpu_hold |-> hold_t.busy)
    else $error("hold-off without running timer");
  delay_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_DELAY |-> sres_t.busy)
    else $error("reset delay without running timer");
endmodule // reset_source_flag_logic

// >>> sim/reset_source_flag_logic_tb.sv
// self-checking bench for the reset source flag logic
`timescale 1ns/1ps
module reset_source_flag_logic_tb;
  import rsf_pkg::*;
  // short counts keep the run small
  localparam int HOLD_SIM = 20;
  localparam int SRST_SIM = 8;
  logic clk_sys = 1'b0;
  logic rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic brownout_det, watchdog_timeout, low_power, halt_enter, status_clr;
  logic cpu_hold, irq_disable, timer_off, port_input, sp_top, sp_zero, pc_clear;
  logic watchdog_restart, system_clock_keep_on, irq;
  logic [7:0] good [4] = '{LEVEL_CODE_A, LEVEL_CODE_B, LEVEL_CODE_C, LEVEL_CODE_D};
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed = 3;
  int hold_n, init_n, zero_n, code, m;
  // register model: cause, status, irq status
  int cause_m, stat_m, irq_m;

  reset_source_flag_logic #(.HOLD_CYC(HOLD_SIM), .SRESET_CYC(SRST_SIM)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .brownout_det(brownout_det),
    .watchdog_timeout(watchdog_timeout), .low_power(low_power),
    .halt_enter(halt_enter), .status_clr(status_clr), .cpu_hold(cpu_hold),
    .irq_disable(irq_disable), .timer_off(timer_off), .port_input(port_input),
    .sp_top(sp_top), .sp_zero(sp_zero), .pc_clear(pc_clear),
    .watchdog_restart(watchdog_restart),
    .system_clock_keep_on(system_clock_keep_on), .irq(irq)
  );

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // hang guard, the full run needs a few hundred cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // no own limit: only the hang guard ends a wait
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input int exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // one-cycle pulse: 0 timeout, 1 halt, 2 status clear
  task automatic pulse(input int k);
    @(posedge clk_sys);
    watchdog_timeout <= (k == 0);
    halt_enter <= (k == 1);
    status_clr <= (k == 2);
    @(posedge clk_sys);
    {watchdog_timeout, halt_enter, status_clr} <= 3'h0;
  endtask

  // count hold and init pulses; with hold set, stops once hold has fallen
  task automatic settle(input bit hold);
    int n;
    n = 0;
    hold_n = 0;
    init_n = 0;
    zero_n = 0;
    while (n < SRST_SIM + HOLD_SIM + 20)
    begin
      @(posedge clk_sys);
      n++;
      hold_n += cpu_hold;
      init_n += port_input & timer_off & irq_disable & sp_top & watchdog_restart;
      zero_n += sp_zero & pc_clear;
      if (hold && hold_n > 0 && cpu_hold === 1'b0)
        n = 1000;
    end
  endtask

  initial
  begin
    {rst_n, psel, penable, pwrite, brownout_det, watchdog_timeout} = '0;
    {low_power, halt_enter, status_clr} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cause_m = 0;
    stat_m = 0;
    irq_m = 0;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    check({irq_disable, timer_off, port_input, sp_top, watchdog_restart}, 5'h1f);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(OFS_CAUSE, 0);
    rd_chk(OFS_STATUS, 0);
    rd_chk(OFS_LEVEL, LEVEL_POR);
    rd_chk(OFS_WDOG_CTL, WCTL_POR);
    rd_chk(OFS_IRQ_MASK, 0);
    // flags ignore written ones, unused bits read zero
    apb(1'b1, OFS_CAUSE, 32'hffffffff);
    rd_chk(OFS_CAUSE, 8'h80);
    check(system_clock_keep_on, 1'b1);
    apb(1'b1, OFS_STATUS, 32'h3);
    rd_chk(OFS_STATUS, 0);
    rd_chk(8'h20, 0);
    check(err, 1'b1);
    // brownout while halted is ignored
    low_power <= 1'b1;
    brownout_det <= 1'b1;
    settle(1'b0);
    brownout_det <= 1'b0;
    low_power <= 1'b0;
    rd_chk(OFS_CAUSE, 8'h80);
    // brownout in run: full reset, flag set, status kept
    brownout_det <= 1'b1;
    settle(1'b1);
    brownout_det <= 1'b0;
    cause_m = 4;
    irq_m |= 1;
    check(init_n, 1);
    rd_chk(OFS_CAUSE, cause_m);
    rd_chk(OFS_STATUS, stat_m);
    // halted timeout: only pc and sp, both status flags
    pulse(1);
    stat_m = 1;
    rd_chk(OFS_STATUS, stat_m);
    low_power <= 1'b1;
    pulse(0);
    settle(1'b0);
    low_power <= 1'b0;
    stat_m = 3;
    irq_m |= 16;
    check(zero_n, 1);
    check(init_n, 0);
    rd_chk(OFS_CAUSE, cause_m);
    rd_chk(OFS_STATUS, stat_m);
    pulse(2);
    rd_chk(OFS_STATUS, 0);
    pulse(1);
    stat_m = 1;
    // every defined level code is kept without reset
    foreach (good[i])
    begin
      apb(1'b1, OFS_LEVEL, good[i]);
      rd_chk(OFS_LEVEL, good[i]);
    end
    // run timeout: full reset with hold-off, timeout set
    pulse(0);
    settle(1'b1);
    stat_m = 3;
    cause_m = 0;
    irq_m |= 8;
    check(hold_n, HOLD_SIM);
    check(init_n, 1);
    rd_chk(OFS_STATUS, stat_m);
    rd_chk(OFS_CAUSE, cause_m);
    rd_chk(OFS_LEVEL, LEVEL_POR);
    // undefined level code, random pick
    do
      code = $random(seed) & 255;
    while (code inside {LEVEL_CODE_A, LEVEL_CODE_B, LEVEL_CODE_C, LEVEL_CODE_D});
    apb(1'b1, OFS_LEVEL, code);
    settle(1'b1);
    cause_m |= 2;
    irq_m |= 2;
    rd_chk(OFS_CAUSE, cause_m);
    rd_chk(OFS_LEVEL, LEVEL_POR);
    apb(1'b1, OFS_WDOG_CTL, WCTL_DISABLE);
    rd_chk(OFS_WDOG_CTL, WCTL_DISABLE);
    // undefined watchdog enable code
    do
      code = $random(seed) & 31;
    while (code inside {WCTL_ENABLE, WCTL_DISABLE});
    apb(1'b1, OFS_WDOG_CTL, code);
    settle(1'b1);
    cause_m |= 1;
    irq_m |= 4;
    rd_chk(OFS_CAUSE, cause_m);
    rd_chk(OFS_WDOG_CTL, WCTL_POR);
    // software has read the flags, now clears them by writing zero
    apb(1'b1, OFS_CAUSE, 32'h0);
    rd_chk(OFS_CAUSE, 0);
    // interrupt: raise, mask, clear; irq is looked at once the write has landed
    rd_chk(OFS_IRQ_ST, irq_m);
    check(irq, 1'b0);
    m = ($random(seed) & 31) | 1;
    apb(1'b1, OFS_IRQ_MASK, m);
    @(negedge clk_sys);
    check(irq, 1'b1);
    apb(1'b1, OFS_IRQ_ST, m);
    irq_m &= ~m;
    @(negedge clk_sys);
    check(irq, (irq_m & m) != 0);
    rd_chk(OFS_IRQ_ST, irq_m);
    // second power-on reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd_chk(OFS_STATUS, 0);
    rd_chk(OFS_IRQ_ST, 0);
    test_done();
  end
endmodule // reset_source_flag_logic_tb
